//--- rtl/fps_pkg.sv
package fps_pkg;
   // comparator flags, all synchronous to clk, active high
   typedef struct packed {
      logic supply_uv;       // below supply_turnoff_level
      logic supply_ov;       // above supply_overvoltage_level
      logic supply_pd;       // below latch_powerdown_level
      logic supply_on;       // above supply_turnon_level
      logic fb_overload;     // above overload_feedback_level
      logic fb_reload;       // above counter_reload_level
      logic fb_low;          // below burst entry level
      logic fb_leave_burst;  // above burst leave level
      logic fb_burst_on;     // burst packet request (hysteresis outside)
      logic zc_ovp;          // above output_overvoltage_level
      logic zc_above_rs;     // above ringing_suppress_level
      logic zc_edge;         // zero crossing seen
      logic zc_hi_cur;       // above high_line_switch_current
      logic zc_lo_cur;       // below low_line_switch_current
      logic overtemp;        // above overtemp_limit
      logic cs_short;        // above winding_short_level
      logic cs_trip;         // peak current / regulation reached
      logic cnt_up;          // valley counter step up
      logic cnt_down;        // valley counter step down
   } fps_sense_type;

   typedef enum logic [3:0] {
      ST_CHARGE = 4'h1,
      ST_SOFT = 4'h2,
      ST_RUN = 4'h4,
      ST_LATCH = 4'h8
   } fps_state_type;
endpackage

//--- rtl/fps_regs.svh
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

`define FPS_CLK_MHZ 100
// times in their printed units
`define FPS_OLP_MS 30
`define FPS_OVP_US 100
`define FPS_SW_NS 190
`define FPS_MAXON_US 30
`define FPS_LEB_NS 330
`define FPS_SS_STEP_MS 3
`define FPS_SS_STEPS 4
`define FPS_RS_SHORT_US_X10 25
`define FPS_RS_LONG_US 25
`define FPS_RESTART_US 42
`define FPS_BEB_MS 24
`define FPS_BURST_KHZ 52
// derived cycle counts; least times round up
`define FPS_OLP_CYC (`FPS_OLP_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_OVP_CYC (`FPS_OVP_US * `FPS_CLK_MHZ)
`define FPS_SW_CYC ((`FPS_SW_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_MAXON_CYC (`FPS_MAXON_US * `FPS_CLK_MHZ)
`define FPS_LEB_CYC ((`FPS_LEB_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_SS_STEP_CYC (`FPS_SS_STEP_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_RS_SHORT_CYC ((`FPS_RS_SHORT_US_X10 * `FPS_CLK_MHZ + 9) / 10)
`define FPS_RS_LONG_CYC (`FPS_RS_LONG_US * `FPS_CLK_MHZ)
`define FPS_RESTART_CYC (`FPS_RESTART_US * `FPS_CLK_MHZ)
`define FPS_BEB_CYC (`FPS_BEB_MS * 1000 * `FPS_CLK_MHZ)
// burst period rounds down, so the rate never drops below nominal
`define FPS_BURST_PER_CYC (`FPS_CLK_MHZ * 1000 / `FPS_BURST_KHZ)
`define FPS_BURST_HALF_CYC (`FPS_BURST_PER_CYC / 2)
`define FPS_VALLEY_ONE 3'h1
`define FPS_VALLEY_MAX 3'h7
`define FPS_SS_LAST 2'h3

`endif

//--- rtl/fps_supervisor.sv
`timescale 1ns/1ps
`include "fps_regs.svh"

module fps_qual_timer #(
   parameter int unsigned LIMIT = 16
) (
   input wire logic clk,   // system clock
   input wire logic reset, // synchronous, active high
   input wire logic cond,  // qualifying condition
   output logic done       // condition held LIMIT cycles
);
   localparam int W = $clog2(LIMIT + 1);
   logic [W-1:0] cnt_r;

   assign done = (cnt_r == W'(LIMIT));

   always_ff @(posedge clk) begin
      if (reset || !cond) begin
         cnt_r <= '0;
      end else if (!done) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule

module fps_supervisor #(
   parameter int unsigned OLP_CYC = `FPS_OLP_CYC,
   parameter int unsigned OVP_CYC = `FPS_OVP_CYC,
   parameter int unsigned BEB_CYC = `FPS_BEB_CYC,
   parameter int unsigned SS_STEP_CYC = `FPS_SS_STEP_CYC,
   parameter int unsigned RESTART_CYC = `FPS_RESTART_CYC
) (
   input wire logic clk,                  // 100 MHz clock
   input wire logic reset,                // synchronous, active high
   input fps_pkg::fps_sense_type sense,   // comparator flags
   output logic gate_on,                  // gate enable to driver
   output logic startup_en,               // start-up charging cell on
   output fps_pkg::fps_state_type state,  // supervisor state
   output logic burst,                    // burst mode active
   output logic high_line,                // high-line thresholds selected
   output logic [2:0] valley_cnt,         // up/down valley counter
   output logic [1:0] ss_step             // soft-start level index
);
   import fps_pkg::*;

   localparam int LEB_M1 = `FPS_LEB_CYC - 1;
   localparam int HALF = `FPS_BURST_HALF_CYC;
   localparam int MAXON = `FPS_MAXON_CYC;

   fps_state_type state_r, state_nxt;
   logic gate_r, gate_nxt;
   logic start_r, start_nxt;
   logic burst_r, burst_nxt;
   logic hl_r;
   logic [2:0] valley_r;
   logic [1:0] ss_r;
   logic [18:0] ss_cnt_r;
   logic [15:0] tcnt_r;
   logic [10:0] bper_r;

   wire active = (state_r == ST_SOFT) || (state_r == ST_RUN);
   wire uvov = sense.supply_uv || sense.supply_ov;
   wire olp_done, ovp_done, sw_done, beb_done;

   // leading-edge blanking masks both current comparators
   wire leb_over = (tcnt_r >= 16'(`FPS_LEB_CYC));
   wire cs_trip_q = leb_over && sense.cs_trip;
   wire cs_short_q = leb_over && sense.cs_short;

   fps_qual_timer #(.LIMIT(OLP_CYC)) u_olp (
      .clk(clk),
      .reset(reset),
      .cond(active && sense.fb_overload && !burst_r),
      .done(olp_done)
   );
   fps_qual_timer #(.LIMIT(OVP_CYC)) u_ovp (
      .clk(clk),
      .reset(reset),
      .cond(active && sense.zc_ovp && !gate_r),
      .done(ovp_done)
   );
   fps_qual_timer #(.LIMIT(`FPS_SW_CYC)) u_sw (
      .clk(clk),
      .reset(reset),
      .cond(active && gate_r && cs_short_q && !burst_r),
      .done(sw_done)
   );
   fps_qual_timer #(.LIMIT(BEB_CYC)) u_beb (
      .clk(clk),
      .reset(reset),
      .cond((state_r == ST_RUN) && !burst_r && (valley_r == `FPS_VALLEY_MAX)
            && sense.fb_low),
      .done(beb_done)
   );

   wire to_latch = ovp_done || sw_done;
   wire to_restart = uvov || olp_done || (sense.overtemp && !burst_r);
   wire ok = active && !to_latch && !to_restart;
   wire ss_wrap = (ss_cnt_r == 19'(SS_STEP_CYC - 1));
   wire ss_done = ss_wrap && (ss_r == `FPS_SS_LAST);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_CHARGE: begin
            if (sense.supply_on && !uvov) begin
               state_nxt = ST_SOFT;
            end
         end
         ST_SOFT, ST_RUN: begin
            if (to_latch) begin
               state_nxt = ST_LATCH;
            end else if (to_restart) begin
               state_nxt = ST_CHARGE;
            end else if (state_r == ST_SOFT && ss_done) begin
               state_nxt = ST_RUN;
            end
         end
         ST_LATCH: begin
            if (sense.supply_pd) begin
               state_nxt = ST_CHARGE;
            end
         end
         default: state_nxt = ST_CHARGE;
      endcase
   end

   // cell charges below turn-off and stops at turn-on, latched or not
   assign start_nxt = sense.supply_uv ? 1'b1 :
                      (sense.supply_on || active) ? 1'b0 : start_r;

   // ringing suppression depends on the zero-crossing level
   wire [15:0] rs_cyc = sense.zc_above_rs ? 16'(`FPS_RS_SHORT_CYC)
                                          : 16'(`FPS_RS_LONG_CYC);
   wire on_norm = (tcnt_r >= rs_cyc && sense.zc_edge)
                  || (tcnt_r >= 16'(RESTART_CYC));
   wire on_burst = (bper_r == 11'h0) && sense.fb_burst_on;
   wire off_any = (tcnt_r >= 16'(MAXON - 1)) || cs_trip_q
                  || (burst_r && bper_r >= 11'(HALF - 1));
   assign gate_nxt = ok && (gate_r ? !off_any : (burst_r ? on_burst : on_norm));

   assign burst_nxt = (state_r != ST_RUN || !ok) ? 1'b0 :
                      burst_r ? !sense.fb_leave_burst : beb_done;

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= ST_CHARGE;
         gate_r <= 1'b0;
         start_r <= 1'b1;
         burst_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         gate_r <= gate_nxt;
         start_r <= start_nxt;
         burst_r <= burst_nxt;
      end
   end

   // time since the last gate edge; saturates so a long idle still restarts
   always_ff @(posedge clk) begin
      if (reset || gate_nxt != gate_r) begin
         tcnt_r <= 16'h0;
      end else if (tcnt_r != 16'hFFFF) begin
         tcnt_r <= tcnt_r + 16'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !burst_r || bper_r == 11'(`FPS_BURST_PER_CYC - 1)) begin
         bper_r <= 11'h0;
      end else begin
         bper_r <= bper_r + 11'h1;
      end
   end

   // level = first level + step * 0.56 V, applied outside
   always_ff @(posedge clk) begin
      if (reset || state_r == ST_CHARGE || state_r == ST_LATCH) begin
         ss_cnt_r <= 19'h0;
         ss_r <= 2'h0;
      end else if (state_r == ST_SOFT) begin
         ss_cnt_r <= ss_wrap ? 19'h0 : ss_cnt_r + 19'h1;
         if (ss_wrap && !ss_done) begin
            ss_r <= ss_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hl_r <= 1'b0;
      end else if (sense.zc_hi_cur) begin
         hl_r <= 1'b1;
      end else if (sense.zc_lo_cur) begin
         hl_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || sense.fb_reload || (burst_r && !burst_nxt)) begin
         valley_r <= `FPS_VALLEY_ONE;
      end else if (sense.cnt_up && valley_r != `FPS_VALLEY_MAX) begin
         valley_r <= valley_r + 3'h1;
      end else if (sense.cnt_down && valley_r != `FPS_VALLEY_ONE) begin
         valley_r <= valley_r - 3'h1;
      end
   end

   assign gate_on = gate_r;
   assign startup_en = start_r;
   assign state = state_r;
   assign burst = burst_r;
   assign high_line = hl_r;
   assign valley_cnt = valley_r;
   assign ss_step = ss_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // a latching fault in the same cycle wins over the restart
   sequence fault_seen;
      active && uvov && !to_latch;
   endsequence
   sequence burst_left;
      burst_r ##1 !burst_r;
   endsequence

   AST_UV_GATE: assert property (fault_seen |=> !gate_r && state_r == ST_CHARGE)
      else $error("gate or state wrong after supply fault");
   AST_UV_CHARGE: assert property (sense.supply_uv |=> start_r)
      else $error("start-up cell not enabled below turn-off");
   AST_BURST_NO_OLP: assert property (burst_r && $past(burst_r) |-> !olp_done)
      else $error("overload timer ran in burst mode");
   AST_LATCH_HOLD: assert property (state_r == ST_LATCH && !sense.supply_pd
      |=> state_r == ST_LATCH)
      else $error("latch left without power-down");
   AST_LATCH_CELL: assert property (state_r == ST_LATCH && sense.supply_on
      && !sense.supply_uv |=> !start_r && !gate_r)
      else $error("start-up cell not stopped at turn-on");
   AST_MAXON: assert property (gate_r |-> tcnt_r < 16'(MAXON))
      else $error("gate high beyond max on time");
   AST_LEB: assert property ($fell(gate_r) && $past(ok) |-> $past(tcnt_r) >= LEB_M1)
      else $error("gate cut inside edge blanking");
   AST_BURST_DUTY: assert property (burst_r && gate_r |-> bper_r < 11'(HALF))
      else $error("burst duty above one half");
   AST_BURST_RELOAD: assert property (burst_left |-> valley_r == `FPS_VALLEY_ONE)
      else $error("valley counter not one after burst");
   AST_SW_LATCH: assert property (sw_done && active |=> state_r == ST_LATCH ##1
      state_r == ST_LATCH || $past(sense.supply_pd))
      else $error("short winding did not latch off");
endmodule

//--- tb/fps_power_stage.sv
`timescale 1ns/1ps

module fps_power_stage (
   input wire logic clk,                  // system clock
   input wire logic reset,                // synchronous, active high
   input fps_pkg::fps_sense_type env,     // bench-set comparator levels
   input wire logic gate_on,              // gate enable from supervisor
   input wire logic [11:0] trip_dly,      // on cycles until current trips, 0 never
   input wire logic [11:0] zc_dly,        // off cycles until zero crossing, 0 never
   output fps_pkg::fps_sense_type sense   // flags seen by supervisor
);
   import fps_pkg::*;
   logic [11:0] on_cnt;
   logic [11:0] off_cnt;
   // counted on the falling edge so every flag moves away from the sampling edge
   always @(negedge clk) begin
      on_cnt <= (gate_on && !reset) ? on_cnt + 12'h001 : 12'h000;
      off_cnt <= (gate_on || reset) ? 12'h000 : off_cnt + 12'h001;
   end
   // current keeps rising while the switch conducts, so the trip flag holds
   always_comb begin
      sense = env;
      sense.cs_trip = env.cs_trip | (trip_dly != 12'h000 && on_cnt >= trip_dly);
      sense.zc_edge = env.zc_edge | (zc_dly != 12'h000 && off_cnt >= zc_dly);
   end
endmodule

//--- tb/fps_supervisor_tb_top.sv
`timescale 1ns/1ps

module fps_supervisor_tb_top;
   import fps_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   fps_sense_type env = '0;
   fps_sense_type sense;
   logic [11:0] trip_dly = 12'h000;
   logic [11:0] zc_dly = 12'h0C8;
   logic gate_on;
   logic startup_en;
   logic burst;
   logic high_line;
   fps_state_type state;
   logic [2:0] valley_cnt;
   logic [1:0] ss_step;
   int errors = 0;
   int n_checks = 0;
   int n;
   int m;

   always #5 clk = ~clk;

   fps_supervisor #(
      .OLP_CYC(200),
      .OVP_CYC(50),
      .BEB_CYC(100),
      .SS_STEP_CYC(40),
      .RESTART_CYC(4200)
   ) fps_supervisor_inst (
      .clk(clk),
      .reset(reset),
      .sense(sense),
      .gate_on(gate_on),
      .startup_en(startup_en),
      .state(state),
      .burst(burst),
      .high_line(high_line),
      .valley_cnt(valley_cnt),
      .ss_step(ss_step)
   );

   fps_power_stage fps_power_stage_inst (
      .clk(clk),
      .reset(reset),
      .env(env),
      .gate_on(gate_on),
      .trip_dly(trip_dly),
      .zc_dly(zc_dly),
      .sense(sense)
   );

   task automatic print_verdict();
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask

   // cnt is the number of falling edges spent waiting
   task automatic wait_gate(input logic lvl, output int cnt);
      cnt = 0;
      while (gate_on !== lvl) begin
         tick(1);
         cnt++;
         if (cnt > 6000) begin
            errors++;
            print_verdict();
         end
      end
   endtask

   task automatic wait_state(input fps_state_type s);
      n = 0;
      while (state !== s && n < 6000) begin
         tick(1);
         n++;
      end
      chk("state", s, state);
      if (state !== s) begin
         print_verdict();
      end
   endtask

   task automatic bring_up();
      env = '0;
      env.supply_on = 1'b1;
      tick(2);
      chk("state", ST_SOFT, state);
      chk("startup_en", 1'b0, startup_en);
      tick(18);
      for (int k = 0; k < 4; k++) begin
         chk("ss_step", k, ss_step);
         tick(40);
      end
      chk("state", ST_RUN, state);
      env.supply_on = 1'b0;
   endtask

   initial begin
      tick(3);
      reset = 1'b0;
      chk("reset outs", 13'h0884, {gate_on, startup_en, state, burst, high_line,
         valley_cnt, ss_step});
      bring_up();
      wait_gate(1'b1, n);
      wait_gate(1'b0, n);
      chk("on cycles", 3000, n);
      trip_dly = 12'h001;
      wait_gate(1'b1, n);
      chk("long ring", n >= 2500 && n <= 2503, 1'b1);
      wait_gate(1'b0, n);
      chk("blank cycles", 34, n);
      env.zc_above_rs = 1'b1;
      wait_gate(1'b1, n);
      chk("short ring", n >= 250 && n <= 253, 1'b1);
      zc_dly = 12'h000;
      wait_gate(1'b0, n);
      wait_gate(1'b1, n);
      chk("restart", n >= 4200 && n <= 4203, 1'b1);
      zc_dly = 12'h0C8;
      // a drop one cycle early must lose all the time counted so far
      env.fb_overload = 1'b1;
      tick(199);
      env.fb_overload = 1'b0;
      tick(5);
      chk("state", ST_RUN, state);
      env.fb_overload = 1'b1;
      tick(199);
      chk("state", ST_RUN, state);
      tick(5);
      chk("state", ST_CHARGE, state);
      for (int i = 0; i < 3; i++) begin
         bring_up();
         env.supply_uv = (i == 0);
         env.supply_ov = (i == 1);
         env.overtemp = (i == 2);
         tick(3);
         chk("state", ST_CHARGE, state);
         chk("gate_on", 1'b0, gate_on);
         chk("startup_en", i == 0, startup_en);
      end
      bring_up();
      env.zc_hi_cur = 1'b1;
      tick(2);
      env.zc_hi_cur = 1'b0;
      tick(2);
      chk("high_line", 1'b1, high_line);
      env.zc_lo_cur = 1'b1;
      tick(2);
      chk("high_line", 1'b0, high_line);
      env.cnt_up = 1'b1;
      tick(9);
      chk("valley", 3'h7, valley_cnt);
      env.fb_reload = 1'b1;
      tick(2);
      chk("valley", 3'h1, valley_cnt);
      env.fb_reload = 1'b0;
      tick(9);
      env.cnt_up = 1'b0;
      env.fb_low = 1'b1;
      tick(98);
      chk("burst", 1'b0, burst);
      tick(5);
      chk("burst", 1'b1, burst);
      env.overtemp = 1'b1;
      env.fb_overload = 1'b1;
      env.cs_short = 1'b1;
      env.fb_burst_on = 1'b1;
      trip_dly = 12'h000;
      wait_gate(1'b1, n);
      wait_gate(1'b0, n);
      wait_gate(1'b1, m);
      chk("burst high", n > 0 && n <= 961, 1'b1);
      chk("burst period", n + m >= 1921 && n + m <= 1925, 1'b1);
      chk("state", ST_RUN, state);
      env = '0;
      env.fb_leave_burst = 1'b1;
      tick(2);
      chk("leave", {1'b0, 3'h1}, {burst, valley_cnt});
      env.fb_leave_burst = 1'b0;
      env.cs_short = 1'b1;
      wait_state(ST_LATCH);
      chk("gate_on", 1'b0, gate_on);
      env.cs_short = 1'b0;
      env.supply_uv = 1'b1;
      tick(2);
      chk("startup_en", 1'b1, startup_en);
      env.supply_uv = 1'b0;
      env.supply_on = 1'b1;
      tick(2);
      chk("latched", {ST_LATCH, 1'b0}, {state, startup_en});
      env.supply_on = 1'b0;
      env.supply_pd = 1'b1;
      tick(2);
      chk("state", ST_CHARGE, state);
      bring_up();
      trip_dly = 12'h001;
      env.zc_ovp = 1'b1;
      wait_state(ST_LATCH);
      print_verdict();
   end
endmodule
